/* shared/timer_pkg.sv */
// package: register map, field layout and encodings of the reload and prescale timer block
package timer_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_RELOAD_A = 8'h04;
  localparam logic [7:0] OFS_RELOAD_B = 8'h08;
  localparam logic [7:0] OFS_SECOND_COUNTER = 8'h0c;
  localparam logic [7:0] OFS_DIVIDER = 8'h10;
  localparam logic [7:0] OFS_SOURCE_SELECT = 8'h14;
  // field widths and positions
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int DIV_W = 8;
  localparam int SEL_W = 3;
  localparam int SELECT_W = 6;
  localparam int FIRST_SEL_LSB = 0;
  localparam int SECOND_SEL_LSB = 3;
  // reset values of the control registers
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [5:0] SELECT_RESET = 6'h00;
  // counter clock source encodings
  localparam logic [2:0] SRC_STOP = 3'h0;
  localparam logic [2:0] SRC_PRESCALED = 3'h1;
  localparam logic [2:0] SRC_INPUT_B = 3'h2;
  localparam logic [2:0] SRC_ACCUM = 3'h3;
  // operating mode encodings
  localparam logic [1:0] MODE_PWM = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_DUAL = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  // bus constants
  localparam logic [2:0] SIZE_WORD = 3'h2;
  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;
endpackage

/* shared/prescale_if.sv */
// interface: register side to clock prescaler
`timescale 1ns/1ps
interface prescale_if;
  import timer_pkg::*;
  logic [DIV_W-1:0] divider_value; // software copy of the divider
  logic run; // prescaler counts while high
  logic pt_mode; // pulse-train adoption rules apply
  logic adopt; // pulse-train start or input b trigger
  logic tick; // one-cycle timer clock enable
  logic [DIV_W-1:0] active_value; // divider now in use
  modport regs(output divider_value, run, pt_mode, adopt, input tick, active_value);
  modport scaler(input divider_value, run, pt_mode, adopt, output tick, active_value);
endinterface

/* rtl/clock_prescaler.sv */
// module: divides the system clock into a timer clock enable
`timescale 1ns/1ps
module clock_prescaler (
  input wire logic hclk,
  input wire logic hresetn,
  prescale_if.scaler ps
);
  import timer_pkg::*;

  logic [DIV_W-1:0] count; // down counter, tick at zero
  logic tick_now; // underflow this cycle
  logic reload; // counter restarts this cycle
  logic [DIV_W:0] gap; // helper: cycles since last restart
  logic [DIV_W-1:0] last_reload; // helper: value of last restart

  assign tick_now = ps.run && (count == '0);
  assign reload = !ps.run || tick_now || (ps.pt_mode && ps.adopt);

  // divider in use: follows the setting while stopped, else outside pulse train only at underflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ps.active_value <= DIV_RESET;
    end else if (!ps.run) begin
      ps.active_value <= ps.divider_value;
    end else if (ps.pt_mode) begin
      if (ps.adopt) begin
        ps.active_value <= ps.divider_value;
      end
    end else if (tick_now) begin
      ps.active_value <= ps.divider_value;
    end
  end

  // count value+1 cycles per tick, so zero means full rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= DIV_RESET;
    end else if (!ps.run || (ps.pt_mode && ps.adopt)) begin
      count <= ps.divider_value; // restart clean on a new train
    end else if (tick_now) begin
      count <= ps.pt_mode ? ps.active_value : ps.divider_value;
    end else begin
      count <= count - 1'b1;
    end
  end

  // tick leaves from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ps.tick <= 1'b0;
    end else begin
      ps.tick <= tick_now;
    end
  end

  // helper for the period check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= '0;
      last_reload <= DIV_RESET;
    end else if (reload) begin
      gap <= '0;
      last_reload <= (ps.run && !(ps.pt_mode && ps.adopt) && ps.pt_mode) ? ps.active_value : ps.divider_value;
    end else begin
      gap <= gap + 1'b1;
    end
  end

  a_prescale_period: assert property (@(posedge hclk) disable iff (!hresetn)
    tick_now |-> gap == {1'b0, last_reload}) else $error("prescaler period is not divider plus one");

  a_divider_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    ps.run && !ps.pt_mode && !tick_now |=> $stable(ps.active_value))
    else $error("divider changed between underflows");

  a_train_adopt: assert property (@(posedge hclk) disable iff (!hresetn)
    ps.run && ps.pt_mode && ps.adopt |=> ps.active_value == $past(ps.divider_value))
    else $error("pulse train did not adopt the divider");
endmodule

/* rtl/timer_reload_prescale_regs.sv */
// module: capture/reload, second counter, prescaler and clock source registers on an ahb-lite slave
`timescale 1ns/1ps
module timer_reload_prescale_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic module_enable,
  input wire logic [1:0] operating_mode_select,
  input wire logic pulse_train_mode,
  input wire logic pulse_train_start,
  input wire logic pulse_train_event_trigger,
  input wire logic input_b_pin,
  input wire logic input_b_rising,
  input wire logic capture_a_strobe,
  input wire logic [15:0] capture_a_value,
  input wire logic capture_b_strobe,
  input wire logic [15:0] capture_b_value,
  output logic [15:0] capture_reload_a,
  output logic [15:0] capture_reload_b,
  output logic [15:0] second_counter,
  output logic prescale_tick,
  output logic first_counter_tick,
  output logic second_counter_tick
);
  import timer_pkg::*;

  // bus slave state
  bus_state_t state; // idle or write data phase
  logic [7:0] write_addr; // latched write address
  logic accept; // address phase taken this edge
  logic write_now; // write data phase, hwdata valid
  logic [DATA_W-1:0] read_mux; // read data before the flop

  // write strobes per register
  logic wr_reload_a;
  logic wr_reload_b;
  logic wr_second;
  logic wr_divider;
  logic wr_select;

  // control registers
  logic [DIV_W-1:0] clock_divider_value; // prescaler setting
  logic [SELECT_W-1:0] counter_clock_source_select; // both source fields

  // input b synchroniser and event detect
  logic b_meta; // first stage, read only by b_sync
  logic b_sync; // pin level in our domain
  logic b_last; // previous synced level
  logic b_event; // selected edge seen

  // mode decode
  logic mode_pwm; // mode 1 or 1a
  logic mode_ext_ok; // external and accumulate sources allowed
  logic pt_active; // pulse-train rules for the prescaler

  // counter clock enables before and after their output flops
  logic [1:0] next_tick;
  logic [1:0] count_tick;

  // prescaler link
  prescale_if ps_link ();

  // the prescaler itself
  clock_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .ps(ps_link)
  );

  // take an address phase only for a selected, ready, non-idle transfer
  assign accept = hsel && hready && htrans[1];
  assign write_now = (state == BUS_WRITE);

  // decode the latched write address
  assign wr_reload_a = write_now && (write_addr == OFS_RELOAD_A);
  assign wr_reload_b = write_now && (write_addr == OFS_RELOAD_B);
  assign wr_second = write_now && (write_addr == OFS_SECOND_COUNTER);
  assign wr_divider = write_now && (write_addr == OFS_DIVIDER);
  assign wr_select = write_now && (write_addr == OFS_SOURCE_SELECT);

  // read mux, reserved bits and unmapped words read zero
  always_comb begin
    read_mux = '0;
    case (haddr[7:0])
      OFS_RELOAD_A: begin
        read_mux[CNT_W-1:0] = capture_reload_a;
      end
      OFS_RELOAD_B: begin
        read_mux[CNT_W-1:0] = capture_reload_b;
      end
      OFS_SECOND_COUNTER: begin
        read_mux[CNT_W-1:0] = second_counter;
      end
      OFS_DIVIDER: begin
        read_mux[DIV_W-1:0] = clock_divider_value;
      end
      OFS_SOURCE_SELECT: begin
        read_mux[SELECT_W-1:0] = counter_clock_source_select;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  // bus state machine: reads answer with no wait, word writes insert one
  // wait so that hwdata is in hand and a following read sees the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= BUS_IDLE;
      hreadyout <= 1'b1;
      write_addr <= 8'h00;
    end else begin
      case (state)
        BUS_IDLE: begin
          // non-word writes are answered but dropped
          if (accept && hwrite && (hsize == SIZE_WORD)) begin
            state <= BUS_WRITE;
            hreadyout <= 1'b0;
            write_addr <= haddr[7:0];
          end
        end
        BUS_WRITE: begin
          // write commits on this edge, release the bus
          state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // read data captured at the address phase, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata <= read_mux;
    end
  end

  // the slave never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // reload a: no reset, contents after power-up are undefined
  // hardware capture has priority over a software write in the same cycle
  always_ff @(posedge hclk) begin
    if (capture_a_strobe) begin
      capture_reload_a <= capture_a_value;
    end else if (wr_reload_a && module_enable) begin
      capture_reload_a <= hwdata[CNT_W-1:0];
    end
  end

  // reload b: no reset, same write gating as reload a
  always_ff @(posedge hclk) begin
    if (capture_b_strobe) begin
      capture_reload_b <= capture_b_value;
    end else if (wr_reload_b && module_enable) begin
      capture_reload_b <= hwdata[CNT_W-1:0];
    end
  end

  // second counter: no reset, software load wins over a count
  always_ff @(posedge hclk) begin
    if (wr_second && module_enable) begin
      second_counter <= hwdata[CNT_W-1:0];
    end else if (second_counter_tick) begin
      second_counter <= second_counter - 1'b1;
    end
  end

  // prescaler setting, writable at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_divider_value <= DIV_RESET;
    end else if (wr_divider) begin
      clock_divider_value <= hwdata[DIV_W-1:0];
    end
  end

  // clock source fields for both counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_clock_source_select <= SELECT_RESET;
    end else if (wr_select) begin
      counter_clock_source_select <= hwdata[SELECT_W-1:0];
    end
  end

  // input b pin crosses in through two flops before any logic looks at it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_meta <= 1'b0;
      b_sync <= 1'b0;
      b_last <= 1'b0;
    end else begin
      b_meta <= input_b_pin;
      b_sync <= b_meta;
      b_last <= b_sync;
    end
  end

  // edge of interest chosen by the polarity input
  assign b_event = input_b_rising ? (b_sync && !b_last) : (!b_sync && b_last);

  // mode decode; only modes 1 and 3 may use external sources
  assign mode_pwm = (operating_mode_select == MODE_PWM);
  assign mode_ext_ok = mode_pwm || (operating_mode_select == MODE_DUAL);
  assign pt_active = mode_pwm && pulse_train_mode;

  // prescaler control
  assign ps_link.divider_value = clock_divider_value;
  assign ps_link.run = module_enable;
  assign ps_link.pt_mode = pt_active;
  assign ps_link.adopt = pulse_train_start || (pulse_train_event_trigger && b_event);

  // source decode per counter; accumulate is the prescaled clock while b is high
  for (genvar i = 0; i < 2; i++) begin : g_src
    logic [SEL_W-1:0] sel; // this counter's source field
    assign sel = counter_clock_source_select[i*SEL_W +: SEL_W];
    always_comb begin
      case (sel)
        SRC_STOP: begin
          next_tick[i] = 1'b0;
        end
        SRC_PRESCALED: begin
          next_tick[i] = module_enable && ps_link.tick;
        end
        SRC_INPUT_B: begin
          next_tick[i] = module_enable && mode_ext_ok && b_event;
        end
        SRC_ACCUM: begin
          next_tick[i] = module_enable && mode_ext_ok && ps_link.tick && b_sync;
        end
        default: begin
          next_tick[i] = 1'b0;
        end
      endcase
    end
  end

  // counter clock enables leave from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_tick <= 2'h0;
      prescale_tick <= 1'b0;
    end else begin
      count_tick <= next_tick;
      prescale_tick <= ps_link.tick;
    end
  end

  assign first_counter_tick = count_tick[0];
  assign second_counter_tick = count_tick[1];

  // checks
  a_reload_a_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_reload_a && !module_enable && !capture_a_strobe |=> $stable(capture_reload_a))
    else $error("reload a written while disabled");

  a_reload_a_take: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_reload_a && module_enable && !capture_a_strobe |=> capture_reload_a == $past(hwdata[15:0]))
    else $error("reload a missed an enabled write");

  a_reload_b_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_reload_b && !module_enable && !capture_b_strobe |=> $stable(capture_reload_b))
    else $error("reload b written while disabled");

  a_second_load: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_second |=> second_counter == ($past(module_enable) ? $past(hwdata[15:0]) :
      $past(second_counter) - {15'h0000, $past(second_counter_tick)}))
    else $error("second counter load gating wrong");

  a_second_read: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !hwrite && haddr[7:0] == OFS_SECOND_COUNTER |=> hrdata == {16'h0000, $past(second_counter)})
    else $error("second counter read is not live");

  a_src_stopped: assert property (@(posedge hclk) disable iff (!hresetn)
    counter_clock_source_select[2:0] == SRC_STOP || counter_clock_source_select[2] |=> !first_counter_tick)
    else $error("stopped first counter still clocked");

  a_src_ext_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    counter_clock_source_select[5:4] == 2'b01 && !mode_ext_ok |=> !second_counter_tick)
    else $error("external source used outside modes 1 and 3");

  a_src_prescaled: assert property (@(posedge hclk) disable iff (!hresetn)
    counter_clock_source_select[2:0] == SRC_PRESCALED && module_enable |=> first_counter_tick == prescale_tick)
    else $error("prescaled source does not follow the timer clock");

  a_bus_write_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    state == BUS_IDLE && accept && hwrite && hsize == SIZE_WORD |=> !hreadyout ##1 hreadyout)
    else $error("write wait state is not one cycle");
endmodule

/* verification/tb_timer_reload_prescale_regs.sv */
// testbench: bus, prescaler and clock source checks of the reload and prescale timer block
`timescale 1ns/1ps
module tb_timer_reload_prescale_regs;
  import timer_pkg::*;
  logic hclk = 1'b0; // system clock, 50 ns period
  logic hresetn = 1'b0; // active low reset
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = SIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic module_enable = 1'b0;
  logic [1:0] operating_mode_select = MODE_DUAL;
  logic pulse_train_mode = 1'b0;
  logic pulse_train_start = 1'b0;
  logic pulse_train_event_trigger = 1'b0;
  logic input_b_pin = 1'b0;
  logic input_b_rising = 1'b1;
  logic [15:0] capture_reload_a;
  logic [15:0] capture_reload_b;
  logic [15:0] second_counter;
  logic prescale_tick;
  logic first_counter_tick;
  logic second_counter_tick;
  logic [31:0] rd; // last read data
  int err_count = 0;
  int n_compared = 0;
  int first_ticks = 0; // counter clock enables seen
  int second_ticks = 0;

  // capture inputs stay quiet: only the software path is under test here
  timer_reload_prescale_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .module_enable(module_enable),
    .operating_mode_select(operating_mode_select), .pulse_train_mode(pulse_train_mode),
    .pulse_train_start(pulse_train_start), .pulse_train_event_trigger(pulse_train_event_trigger),
    .input_b_pin(input_b_pin), .input_b_rising(input_b_rising), .capture_a_strobe(1'b0),
    .capture_a_value(16'h0), .capture_b_strobe(1'b0), .capture_b_value(16'h0),
    .capture_reload_a(capture_reload_a), .capture_reload_b(capture_reload_b),
    .second_counter(second_counter), .prescale_tick(prescale_tick),
    .first_counter_tick(first_counter_tick), .second_counter_tick(second_counter_tick));

  // clock generator
  always #25 hclk = ~hclk;

  // tick tallies, sampled mid-cycle where outputs are settled
  always @(negedge hclk) begin
    if (first_counter_tick === 1'b1) first_ticks++;
    if (second_counter_tick === 1'b1) second_ticks++;
  end

  // compare and report
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single ahb-lite transfer; waits on hready, no cycle count assumed
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= SIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask

  task rdr(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, rd);
  endtask

  // lead: cycles until next prescale tick; g: cycles from that tick to the one after
  task gap(output int lead, output int g);
    lead = 0;
    g = 0;
    @(negedge hclk);
    while (prescale_tick !== 1'b1 && lead < 600) begin
      @(negedge hclk);
      lead++;
    end
    do begin
      @(negedge hclk);
      g++;
    end while (prescale_tick !== 1'b1 && g < 600);
  endtask

  // steady gap after any pending change has settled
  task steady(input int exp, input string m);
    int lead;
    int g;
    gap(lead, g);
    gap(lead, g);
    chk(g, exp, m);
    @(posedge hclk); // hand back on a rising edge so callers drive there
  endtask

  task pulse_b(input logic lvl);
    input_b_pin <= lvl;
    idle(6);
    input_b_pin <= ~lvl;
    idle(6);
  endtask

  task t_reset;
    rdr(OFS_DIVIDER);
    chk(rd, {24'h0, DIV_RESET}, "divider reset");
    rdr(OFS_SOURCE_SELECT);
    chk(rd, {26'h0, SELECT_RESET}, "select reset");
    rdr(8'h00);
    chk(rd, 32'h0, "unmapped 0x00");
    rdr(8'h18);
    chk(rd, 32'h0, "unmapped 0x18");
    chk(hresp, 1'b0, "hresp okay");
    $display("test reset done");
  endtask

  // writes land only while enabled; upper bits read zero
  task t_enable_gate;
    logic [7:0] ofs [3];
    ofs = '{OFS_RELOAD_A, OFS_RELOAD_B, OFS_SECOND_COUNTER};
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk) module_enable <= 1'b1;
      wr(ofs[i], 32'hffff_1230 + i);
      rdr(ofs[i]);
      chk(rd, 32'h1230 + i, "enabled write");
      @(posedge hclk) module_enable <= 1'b0;
      wr(ofs[i], 32'h0000_beef);
      rdr(ofs[i]);
      chk(rd, 32'h1230 + i, "disabled write dropped");
    end
    chk(capture_reload_a, 16'h1230, "reload a port");
    chk(capture_reload_b, 16'h1231, "reload b port");
    chk(second_counter, 16'h1232, "counter port");
    $display("test enable gate done");
  endtask

  // divide ratios at both ends; a change waits for the running count to underflow
  task t_divider;
    logic [7:0] dv [4];
    int lead;
    int g;
    dv = '{8'h00, 8'h02, 8'hff, 8'h04};
    @(posedge hclk) module_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DIVIDER, {24'hffffff, dv[i]});
      rdr(OFS_DIVIDER);
      chk(rd, {24'h0, dv[i]}, "divider readback");
      gap(lead, g);
      if (i == 3) chk(lead > 200, 1'b1, "old count kept");
      steady(dv[i] + 1, "divide ratio");
    end
    $display("test divider done");
  endtask

  // pulse-train mode adopts only on start or triggered input b event
  task t_pulse_train;
    operating_mode_select <= MODE_PWM;
    pulse_train_mode <= 1'b1;
    wr(OFS_DIVIDER, 32'h1);
    steady(5, "pt not adopted on write");
    @(posedge hclk) pulse_train_start <= 1'b1;
    @(posedge hclk) pulse_train_start <= 1'b0;
    steady(2, "pt adopted on start");
    wr(OFS_DIVIDER, 32'h3);
    pulse_b(1'b1);
    steady(2, "pt not adopted untriggered");
    pulse_train_event_trigger <= 1'b1;
    pulse_b(1'b1);
    steady(4, "pt adopted on event");
    pulse_train_event_trigger <= 1'b0;
    pulse_train_mode <= 1'b0;
    $display("test pulse train done");
  endtask

  // every source code in every mode, input b held high
  task t_sources;
    int exp;
    wr(OFS_DIVIDER, 32'h0);
    input_b_pin <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 8; s++) begin
        operating_mode_select <= m[1:0];
        wr(OFS_SOURCE_SELECT, {26'h3ffffff, s[2:0], s[2:0]});
        rdr(OFS_SOURCE_SELECT);
        chk(rd, {26'h0, s[2:0], s[2:0]}, "select fields");
        idle(4);
        first_ticks = 0;
        second_ticks = 0;
        idle(16);
        exp = (s == 1 || (s == 3 && m[0] == 1'b0)) ? 16 : 0;
        chk(first_ticks, exp, "first source");
        chk(second_ticks, exp, "second source");
      end
    end
    $display("test sources done");
  endtask

  // input b events clock both counters, for each edge polarity
  task t_events;
    operating_mode_select <= MODE_DUAL;
    wr(OFS_SOURCE_SELECT, 32'h12);
    for (int p = 0; p < 2; p++) begin
      input_b_rising <= p[0];
      input_b_pin <= ~p[0];
      idle(8);
      first_ticks = 0;
      second_ticks = 0;
      repeat (3) pulse_b(p[0]);
      idle(6);
      chk(first_ticks, 3, "first event count");
      chk(second_ticks, 3, "second event count");
    end
    $display("test events done");
  endtask

  // read returns the live count after prescaled decrements
  task t_count;
    wr(OFS_SOURCE_SELECT, 32'h0);
    wr(OFS_SECOND_COUNTER, 32'h0100);
    idle(4);
    second_ticks = 0;
    wr(OFS_SOURCE_SELECT, 32'h08);
    idle(20);
    wr(OFS_SOURCE_SELECT, 32'h0);
    idle(4);
    rdr(OFS_SECOND_COUNTER);
    chk(rd, 32'h0100 - second_ticks, "live count read");
    chk(second_counter, 16'h0100 - second_ticks[15:0], "counter port");
    chk(second_ticks > 10, 1'b1, "counter was clocked");
    $display("test count done");
  endtask

  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_enable_gate();
    t_divider();
    t_pulse_train();
    t_sources();
    t_events();
    t_count();
    wrap_up();
  end

  // watchdog: the run needs well under this many cycles
  initial begin
    #(20000 * 50);
    err_count++;
    wrap_up();
  end
endmodule
